// [design/pcg_top.sv]
// performance counter group: counters, overflow status, capture and interrupt
//
// Overview of operation
// - overflow is a carry out of the counter top bit; it wraps.
// - each overflow sets that counter's bit in the overflow status array.
// - a counter keeps counting its event after it has overflowed.
// - per-counter interrupt enables, gated by one group-wide enable.
// - overflow, interrupt and capture act regardless of the status bit.
// - group interrupt goes out as wired edge and as message write.
// - capture is advertised as supported and copies all counters at once.
// - capture comes from a software write, overflow-capture, or external trigger.
// - overflow capture stores the counter's post-wrap value.
// - accesses after a capture write see the new shadow values.
// - interrupt appears only after status, counter and capture are visible.
// - event identifiers are 16 bits; below 0x0080 architected, rest implementation.
// - event 0 counts cycles and ignores the stream filter.
// - event 1 counts each transaction or translation request, filterable.
// - event 2 counts each TLB miss needing a walk, filterable.
// - translation requests of every kind count alike.
// - a counter increments when its selected event occurs.
// - a group holds four counters, each selecting any event.
// - with filtering on, count only events from the matching stream.
`timescale 1ns/10ps
module pcg_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // event sources
  input wire logic cycle_tick,
  input wire logic ev_txn_valid,
  input wire logic [7:0] ev_txn_sid,
  input wire logic ev_miss_valid,
  input wire logic [7:0] ev_miss_sid,
  input wire logic ext_capture,
  // interrupt outputs
  output logic irq_wired,
  output logic msi_req,
  output logic [31:0] msi_addr,
  output logic [31:0] msi_data,
  input wire logic msi_ack
);
  localparam int N = pcg_pkg::NCNT;

  // bus state
  pcg_pkg::pcg_bus_state_type state_q;
  logic [7:0] addr_q;
  logic wr_q;
  logic rd_ok_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic hresp_q;
  // configuration and status
  logic [pcg_pkg::EVT_W-1:0] evt_q [N];
  logic [pcg_pkg::SID_W-1:0] fsid_q [N];
  logic [pcg_pkg::CNT_W-1:0] shadow_q [N];
  logic [N-1:0] fen_q;
  logic [N-1:0] ocap_q;
  logic [N-1:0] ovs_q;
  logic [N-1:0] ovs_d;
  logic [N-1:0] inten_q;
  logic gen_q;
  logic msien_q;
  logic [31:0] msi_addr_q;
  logic [31:0] msi_data_q;
  logic irq_trig_q;
  logic irq_pend_q;
  logic irq_q;
  logic msi_req_q;
  // counter outputs
  wire [pcg_pkg::CNT_W-1:0] cnt_w [N];
  wire [N-1:0] ovf_w;

  // address phase accept and decode
  wire acc_w;
  wire size_ok;
  wire [1:0] idx;
  wire in_cnt;
  wire in_evt;
  wire in_sh;
  wire hit_ovs;
  wire wr_ovs_set;
  wire wr_ovs_clr;
  wire wr_inten;
  wire wr_irqctl;
  wire wr_capr;
  wire wr_msia;
  wire wr_msid;
  wire [N-1:0] ovs_set_sw;
  wire [N-1:0] ovs_clr_sw;
  wire sw_cap;
  wire cap_all;
  wire irq_trig_d;
  wire [31:0] rd_evt;
  wire [31:0] rd_mux;

  assign acc_w = hsel && hready && htrans[1];
  assign size_ok = hsize == pcg_pkg::HSIZE_WORD;
  assign idx = addr_q[3:2];
  assign in_cnt = addr_q[7:4] == pcg_pkg::OFS_CNT[7:4] && addr_q[1:0] == 2'h0;
  assign in_evt = addr_q[7:4] == pcg_pkg::OFS_EVTYPE[7:4] && addr_q[1:0] == 2'h0;
  assign in_sh = addr_q[7:4] == pcg_pkg::OFS_SHADOW[7:4] && addr_q[1:0] == 2'h0;
  assign hit_ovs = addr_q == pcg_pkg::OFS_OVS_SET || addr_q == pcg_pkg::OFS_OVS_CLR;
  assign wr_ovs_set = wr_q && addr_q == pcg_pkg::OFS_OVS_SET;
  assign wr_ovs_clr = wr_q && addr_q == pcg_pkg::OFS_OVS_CLR;
  assign wr_inten = wr_q && addr_q == pcg_pkg::OFS_INTEN;
  assign wr_irqctl = wr_q && addr_q == pcg_pkg::OFS_IRQ_CTRL;
  assign wr_capr = wr_q && addr_q == pcg_pkg::OFS_CAPR;
  assign wr_msia = wr_q && addr_q == pcg_pkg::OFS_MSI_ADDR;
  assign wr_msid = wr_q && addr_q == pcg_pkg::OFS_MSI_DATA;
  assign ovs_set_sw = wr_ovs_set ? hwdata[N-1:0] : '0;
  assign ovs_clr_sw = wr_ovs_clr ? hwdata[N-1:0] : '0;
  assign sw_cap = wr_capr && hwdata[pcg_pkg::CAPR_BIT];
  // any trigger copies all counters in one edge
  assign cap_all = sw_cap || |(ovf_w & ocap_q) || ext_capture;
  // set beats a clear in the same cycle
  assign ovs_d = (ovs_q & ~ovs_clr_sw) | ovs_set_sw | ovf_w;
  // status bit plays no part in the interrupt decision
  assign irq_trig_d = gen_q && |(ovf_w & inten_q);

  assign rd_evt = (32'(ocap_q[idx]) << pcg_pkg::OCAP_BIT)
                | (32'(fen_q[idx]) << pcg_pkg::FEN_BIT)
                | (32'(fsid_q[idx]) << pcg_pkg::SID_LSB)
                | (32'(evt_q[idx]) << pcg_pkg::EVT_LSB);
  assign rd_mux = !rd_ok_q ? pcg_pkg::RST_WORD :
                  in_cnt ? cnt_w[idx] :
                  in_evt ? rd_evt :
                  in_sh ? shadow_q[idx] :
                  hit_ovs ? 32'(ovs_q) :
                  addr_q == pcg_pkg::OFS_INTEN ? 32'(inten_q) :
                  addr_q == pcg_pkg::OFS_IRQ_CTRL ?
                    ((32'(msien_q) << pcg_pkg::MSIEN_BIT) | (32'(gen_q) << pcg_pkg::GEN_BIT)) :
                  addr_q == pcg_pkg::OFS_CFGR ? pcg_pkg::CFGR_VAL :
                  addr_q == pcg_pkg::OFS_MSI_ADDR ? msi_addr_q :
                  addr_q == pcg_pkg::OFS_MSI_DATA ? msi_data_q :
                  pcg_pkg::RST_WORD;

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;
  assign irq_wired = irq_q;
  assign msi_req = msi_req_q;
  assign msi_addr = msi_addr_q;
  assign msi_data = msi_data_q;

  // bus slave: writes take no wait state, reads take one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= pcg_pkg::BUS_IDLE;
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      rd_ok_q <= 1'b0;
      hreadyout_q <= 1'b1;
      hrdata_q <= pcg_pkg::RST_WORD;
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
      unique case (state_q)
        pcg_pkg::BUS_IDLE: begin
          wr_q <= acc_w && hwrite && size_ok;
          if (acc_w) begin
            addr_q <= haddr[7:0];
            rd_ok_q <= size_ok;
          end
          if (acc_w && !hwrite) begin
            state_q <= pcg_pkg::BUS_RDWAIT;
            hreadyout_q <= 1'b0;
          end
        end
        pcg_pkg::BUS_RDWAIT: begin
          // read data sampled after the previous write has landed
          hrdata_q <= rd_mux;
          hreadyout_q <= 1'b1;
          state_q <= pcg_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // group configuration, status and interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovs_q <= '0;
      inten_q <= '0;
      gen_q <= 1'b0;
      msien_q <= 1'b0;
      msi_addr_q <= pcg_pkg::RST_WORD;
      msi_data_q <= pcg_pkg::RST_WORD;
      irq_trig_q <= 1'b0;
      irq_pend_q <= 1'b0;
      irq_q <= 1'b0;
      msi_req_q <= 1'b0;
    end else begin
      ovs_q <= ovs_d;
      if (wr_inten) begin
        inten_q <= hwdata[N-1:0];
      end
      if (wr_irqctl) begin
        gen_q <= hwdata[pcg_pkg::GEN_BIT];
        msien_q <= hwdata[pcg_pkg::MSIEN_BIT];
      end
      if (wr_msia) begin
        msi_addr_q <= hwdata;
      end
      if (wr_msid) begin
        msi_data_q <= hwdata;
      end
      // set on the same edge as status and shadow updates, one cycle behind the counter wrap
      irq_trig_q <= irq_trig_d;
      // back-to-back triggers are spaced out, but only one can wait, so a third in a row is merged
      irq_q <= (irq_trig_q || irq_pend_q) && !irq_q;
      irq_pend_q <= (irq_trig_q || irq_pend_q) && irq_q;
      if (irq_q && msien_q) begin
        msi_req_q <= 1'b1;
      end else if (msi_ack) begin
        msi_req_q <= 1'b0;
      end
    end
  end

  // per-counter configuration, shadows and counter instances
  genvar n;
  generate
    for (n = 0; n < N; n++) begin : g_cnt
      pcg_cnt_if cif ();
      wire wr_cnt_n;
      wire wr_evt_n;
      assign wr_cnt_n = wr_q && in_cnt && idx == 2'(n);
      assign wr_evt_n = wr_q && in_evt && idx == 2'(n);
      assign cif.evtype = evt_q[n];
      assign cif.filt_en = fen_q[n];
      assign cif.filt_sid = fsid_q[n];
      assign cif.ev_cyc = cycle_tick;
      assign cif.ev_txn = ev_txn_valid;
      assign cif.txn_sid = ev_txn_sid;
      assign cif.ev_miss = ev_miss_valid;
      assign cif.miss_sid = ev_miss_sid;
      assign cif.wr_en = wr_cnt_n;
      assign cif.wdata = hwdata;
      assign cnt_w[n] = cif.count;
      assign ovf_w[n] = cif.ovf;

      pcg_counter u_cnt (
        .hclk(hclk),
        .hresetn(hresetn),
        .cif(cif.cnt)
      );

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          evt_q[n] <= pcg_pkg::RST_EVT;
          fsid_q[n] <= pcg_pkg::RST_SID;
          fen_q[n] <= 1'b0;
          ocap_q[n] <= 1'b0;
          shadow_q[n] <= pcg_pkg::RST_CNT;
        end else begin
          if (wr_evt_n) begin
            evt_q[n] <= hwdata[pcg_pkg::EVT_LSB +: pcg_pkg::EVT_W];
            fsid_q[n] <= hwdata[pcg_pkg::SID_LSB +: pcg_pkg::SID_W];
            fen_q[n] <= hwdata[pcg_pkg::FEN_BIT];
            ocap_q[n] <= hwdata[pcg_pkg::OCAP_BIT];
          end
          // counter value already post-wrap when its overflow flag is up
          if (cap_all) begin
            shadow_q[n] <= cnt_w[n];
          end
        end
      end

      a_shadow_post_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        ovf_w[n] && ocap_q[n] |=> shadow_q[n] == '0)
        else $error("overflow capture did not store post-wrap value");
      a_capture_all_sw: assert property (@(posedge hclk) disable iff (!hresetn)
        sw_cap |=> shadow_q[n] == $past(cnt_w[n]))
        else $error("software capture missed a counter");
      a_capture_all_ext: assert property (@(posedge hclk) disable iff (!hresetn)
        ext_capture |=> shadow_q[n] == $past(cnt_w[n]))
        else $error("external capture missed a counter");
      a_ovs_per_counter: assert property (@(posedge hclk) disable iff (!hresetn)
        ovf_w[n] |=> ovs_q[n])
        else $error("overflow did not set its own status bit");
      // shadows move only on a capture
      a_shadow_still: assert property (@(posedge hclk) disable iff (!hresetn)
        !cap_all |=> $stable(shadow_q[n]))
        else $error("shadow changed without a capture");
    end
  endgenerate

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_ovf_irq;
    gen_q && |(ovf_w & inten_q);
  endsequence
  sequence s_status_seen;
    ##1 (ovs_q & $past(ovf_w)) == $past(ovf_w);
  endsequence

  a_ovs_on_ovf: assert property ((|ovf_w) |-> s_status_seen)
    else $error("overflow did not set status");
  a_irq_after_ovs: assert property (s_ovf_irq |-> s_status_seen ##[1:2] irq_q)
    else $error("interrupt not raised after status update");
  a_irq_gated_off: assert property ((!gen_q) [*4] |-> !irq_q && !irq_trig_q)
    else $error("interrupt raised with group enable off");
  a_irq_one_cycle: assert property (irq_q |=> !irq_q)
    else $error("wired interrupt wider than one cycle");
  a_ovs_sw_clear: assert property (wr_ovs_clr && hwdata[0] && !ovf_w[0] |=> !ovs_q[0])
    else $error("status bit not cleared");
  a_read_one_wait: assert property (acc_w && !hwrite && state_q == pcg_pkg::BUS_IDLE
    |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing wrong");
  a_msi_follows_irq: assert property (irq_q && msien_q |=> msi_req)
    else $error("message interrupt not requested");

  // message request handshake
  a_msi_held_ack: assert property (msi_req && !msi_ack |=> msi_req)
    else $error("message request dropped before acknowledge");
  a_msi_drop_ack: assert property (msi_req && msi_ack && !(irq_q && msien_q)
    |=> !msi_req)
    else $error("message request held after acknowledge");
  // bus answer, status and interrupt enables
  a_write_no_wait: assert property (acc_w && hwrite |=> hreadyout)
    else $error("write inserted a wait state");
  a_ovs_held: assert property (|ovs_q && !wr_ovs_clr
    |=> (ovs_q & $past(ovs_q)) == $past(ovs_q))
    else $error("status bit lost without a clear");
  a_gen_blocks_trig: assert property (!gen_q |=> !irq_trig_q)
    else $error("interrupt triggered with group enable off");
  a_inten_masks: assert property (!(|(ovf_w & inten_q)) |=> !irq_trig_q)
    else $error("interrupt triggered without an enabled overflow");
endmodule

// [design/pcg_pkg.sv]
// constants shared by the counter group and its counters
package pcg_pkg;
  localparam int NCNT = 4;
  localparam int CNT_W = 32;
  localparam int EVT_W = 16;
  localparam int SID_W = 8;
  // register byte offsets, decoded from haddr[7:0]
  localparam logic [7:0] OFS_CNT = 8'h00;
  localparam logic [7:0] OFS_EVTYPE = 8'h40;
  localparam logic [7:0] OFS_SHADOW = 8'h80;
  localparam logic [7:0] OFS_OVS_SET = 8'hc0;
  localparam logic [7:0] OFS_OVS_CLR = 8'hc4;
  localparam logic [7:0] OFS_INTEN = 8'hc8;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'hcc;
  localparam logic [7:0] OFS_CAPR = 8'hd0;
  localparam logic [7:0] OFS_CFGR = 8'hd4;
  localparam logic [7:0] OFS_MSI_ADDR = 8'hd8;
  localparam logic [7:0] OFS_MSI_DATA = 8'hdc;
  // field positions
  localparam int EVT_LSB = 0;
  localparam int SID_LSB = 16;
  localparam int FEN_BIT = 24;
  localparam int OCAP_BIT = 25;
  localparam int GEN_BIT = 0;
  localparam int MSIEN_BIT = 1;
  localparam int CAPR_BIT = 0;
  localparam int CFGR_CAP_BIT = 0;
  localparam int CFGR_MSI_BIT = 1;
  localparam int CFGR_NCNT_LSB = 8;
  // event identifiers
  localparam logic [EVT_W-1:0] EVT_CYCLE = 16'h0000;
  localparam logic [EVT_W-1:0] EVT_TXN = 16'h0001;
  localparam logic [EVT_W-1:0] EVT_MISS = 16'h0002;
  localparam logic [EVT_W-1:0] EVT_ARCH_MAX = 16'h007f;
  // reset values
  localparam logic [CNT_W-1:0] RST_CNT = 32'h0000_0000;
  localparam logic [EVT_W-1:0] RST_EVT = 16'h0000;
  localparam logic [SID_W-1:0] RST_SID = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] CFGR_VAL = (32'(NCNT - 1) << CFGR_NCNT_LSB)
                                   | (32'h1 << CFGR_MSI_BIT) | (32'h1 << CFGR_CAP_BIT);
  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_RDWAIT = 1'b1
  } pcg_bus_state_type;
endpackage

// [design/pcg_cnt_if.sv]
// links the group register logic to one counter
`timescale 1ns/10ps
interface pcg_cnt_if;
  logic [15:0] evtype;
  logic filt_en;
  logic [7:0] filt_sid;
  logic ev_cyc;
  logic ev_txn;
  logic [7:0] txn_sid;
  logic ev_miss;
  logic [7:0] miss_sid;
  logic wr_en;
  logic [31:0] wdata;
  logic [31:0] count;
  logic ovf;
  modport ctl(output evtype, filt_en, filt_sid, ev_cyc, ev_txn, txn_sid, ev_miss, miss_sid,
              wr_en, wdata, input count, ovf);
  modport cnt(input evtype, filt_en, filt_sid, ev_cyc, ev_txn, txn_sid, ev_miss, miss_sid,
              wr_en, wdata, output count, ovf);
endinterface

// [design/pcg_counter.sv]
// one event counter with event select, stream filter and overflow pulse
`timescale 1ns/10ps
module pcg_counter (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link to the group
  pcg_cnt_if.cnt cif
);
  logic [pcg_pkg::CNT_W-1:0] count_q;
  logic ovf_q;
  wire evt_arch;
  wire sel_cyc;
  wire sel_txn;
  wire sel_miss;
  wire txn_match;
  wire miss_match;
  wire hit;
  wire [pcg_pkg::CNT_W:0] sum_w;

  assign evt_arch = cif.evtype <= pcg_pkg::EVT_ARCH_MAX;
  assign sel_cyc = evt_arch && cif.evtype == pcg_pkg::EVT_CYCLE;
  assign sel_txn = evt_arch && cif.evtype == pcg_pkg::EVT_TXN;
  assign sel_miss = evt_arch && cif.evtype == pcg_pkg::EVT_MISS;
  assign txn_match = !cif.filt_en || cif.txn_sid == cif.filt_sid;
  assign miss_match = !cif.filt_en || cif.miss_sid == cif.filt_sid;
  // cycle event ignores the stream filter
  assign hit = (sel_cyc && cif.ev_cyc) || (sel_txn && cif.ev_txn && txn_match)
             || (sel_miss && cif.ev_miss && miss_match);
  assign sum_w = {1'b0, count_q} + {{pcg_pkg::CNT_W{1'b0}}, 1'b1};
  assign cif.count = count_q;
  assign cif.ovf = ovf_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= pcg_pkg::RST_CNT;
      ovf_q <= 1'b0;
    end else begin
      if (cif.wr_en) begin
        count_q <= cif.wdata;
      end else if (hit) begin
        count_q <= sum_w[pcg_pkg::CNT_W-1:0];
      end
      ovf_q <= hit && !cif.wr_en && sum_w[pcg_pkg::CNT_W];
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_wrap_flags_ovf: assert property (hit && !cif.wr_en && (&count_q)
    |=> ovf_q && count_q == '0)
    else $error("wrap did not raise overflow");
  a_count_after_ovf: assert property (ovf_q && hit && !cif.wr_en |=> count_q == 32'h1)
    else $error("counting stopped after overflow");
endmodule

// [sim/pcg_evt_src.sv]
// event source model standing in for the translation and tlb units
`timescale 1ns/10ps
module pcg_evt_src (
  // clock
  input wire logic hclk,
  // events towards the counter group
  output logic cycle_tick,
  output logic ev_txn_valid,
  output logic [7:0] ev_txn_sid,
  output logic ev_miss_valid,
  output logic [7:0] ev_miss_sid,
  output logic ext_capture,
  // message interrupt handshake
  input wire logic msi_req,
  output logic msi_ack
);
  initial begin
    cycle_tick = 1'b0;
    ev_txn_valid = 1'b0;
    ev_txn_sid = 8'h00;
    ev_miss_valid = 1'b0;
    ev_miss_sid = 8'h00;
    ext_capture = 1'b0;
    msi_ack = 1'b0;
  end
  // one request or one miss, a single cycle each
  task automatic send(input logic miss, input logic [7:0] sid);
    @(posedge hclk);
    if (miss) begin
      ev_miss_valid <= 1'b1;
      ev_miss_sid <= sid;
    end else begin
      ev_txn_valid <= 1'b1;
      ev_txn_sid <= sid;
    end
    @(posedge hclk);
    ev_txn_valid <= 1'b0;
    ev_miss_valid <= 1'b0;
    // idle id lines do not keep the last value
    ev_txn_sid <= ~ev_txn_sid;
    ev_miss_sid <= ~ev_miss_sid;
  endtask
  // time base active for exactly n cycles
  task automatic ticks(input int n);
    @(posedge hclk);
    cycle_tick <= 1'b1;
    repeat (n) @(posedge hclk);
    cycle_tick <= 1'b0;
  endtask
  task automatic capture();
    @(posedge hclk);
    ext_capture <= 1'b1;
    @(posedge hclk);
    ext_capture <= 1'b0;
  endtask
  // accepts each message write one cycle after it is raised
  always @(posedge hclk) begin
    msi_ack <= msi_req & ~msi_ack;
  end
endmodule

// [sim/perf_counter_overflow_capture_tb.sv]
// self-checking bench for the performance counter group
`timescale 1ns/10ps
module perf_counter_overflow_capture_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq_wired, msi_req, msi_ack;
  logic [31:0] hrdata, msi_addr, msi_data;
  logic cycle_tick, ev_txn_valid, ev_miss_valid, ext_capture;
  logic [7:0] ev_txn_sid, ev_miss_sid;
  logic [31:0] irq_n = 32'h0;
  logic msi_seen = 1'b0;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  always #50 hclk = ~hclk;
  pcg_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cycle_tick(cycle_tick),
    .ev_txn_valid(ev_txn_valid), .ev_txn_sid(ev_txn_sid), .ev_miss_valid(ev_miss_valid),
    .ev_miss_sid(ev_miss_sid), .ext_capture(ext_capture), .irq_wired(irq_wired),
    .msi_req(msi_req), .msi_addr(msi_addr), .msi_data(msi_data), .msi_ack(msi_ack));
  pcg_evt_src i_src (.hclk(hclk), .cycle_tick(cycle_tick), .ev_txn_valid(ev_txn_valid),
    .ev_txn_sid(ev_txn_sid), .ev_miss_valid(ev_miss_valid), .ev_miss_sid(ev_miss_sid),
    .ext_capture(ext_capture), .msi_req(msi_req), .msi_ack(msi_ack));
  always @(posedge hclk) begin
    if (irq_wired === 1'b1) irq_n <= irq_n + 32'h1;
    if (msi_req === 1'b1) msi_seen <= 1'b1;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     input logic [2:0] sz, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, pcg_pkg::HSIZE_WORD, x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, pcg_pkg::HSIZE_WORD, x);
    chk(x, exp);
  endtask
  function automatic logic [31:0] evt(input logic [15:0] id, input logic [7:0] sid,
                                      input logic fen, input logic ocap);
    return (32'(id) << pcg_pkg::EVT_LSB) | (32'(sid) << pcg_pkg::SID_LSB)
         | (32'(fen) << pcg_pkg::FEN_BIT) | (32'(ocap) << pcg_pkg::OCAP_BIT);
  endfunction
  task automatic settle();
    repeat (8) @(posedge hclk);
  endtask
  initial begin
    logic [31:0] x;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(pcg_pkg::OFS_CFGR, pcg_pkg::CFGR_VAL);
    rd(pcg_pkg::OFS_OVS_SET, 32'h0);
    rd(pcg_pkg::OFS_CAPR, 32'h0);
    rd(8'he8, 32'h0);
    ahb(1'b1, pcg_pkg::OFS_CNT + 8'h08, 32'h5, 3'h0, x);
    rd(pcg_pkg::OFS_CNT + 8'h08, 32'h0);
    // filter on, filter off, filtered misses, implementation id
    wr(pcg_pkg::OFS_EVTYPE, evt(pcg_pkg::EVT_TXN, 8'h12, 1'b1, 1'b0));
    wr(pcg_pkg::OFS_EVTYPE + 8'h04, evt(pcg_pkg::EVT_TXN, 8'h12, 1'b0, 1'b1));
    wr(pcg_pkg::OFS_EVTYPE + 8'h08, evt(pcg_pkg::EVT_MISS, 8'h34, 1'b1, 1'b0));
    wr(pcg_pkg::OFS_EVTYPE + 8'h0c, evt(16'h0080, 8'h00, 1'b0, 1'b0));
    i_src.send(1'b0, 8'h12);
    i_src.send(1'b0, 8'h55);
    i_src.send(1'b1, 8'h34);
    i_src.send(1'b1, 8'h99);
    i_src.ticks(3);
    rd(pcg_pkg::OFS_CNT, 32'h1);
    rd(pcg_pkg::OFS_CNT + 8'h04, 32'h2);
    rd(pcg_pkg::OFS_CNT + 8'h08, 32'h1);
    rd(pcg_pkg::OFS_CNT + 8'h0c, 32'h0);
    // cycle event ignores a mismatching filter
    wr(pcg_pkg::OFS_EVTYPE + 8'h0c, evt(pcg_pkg::EVT_CYCLE, 8'h77, 1'b1, 1'b0));
    i_src.ticks(10);
    rd(pcg_pkg::OFS_CNT + 8'h0c, 32'ha);
    // overflow with capture, wired and message interrupt
    wr(pcg_pkg::OFS_MSI_ADDR, 32'h0000_1000);
    wr(pcg_pkg::OFS_MSI_DATA, 32'h0000_00a5);
    wr(pcg_pkg::OFS_INTEN, 32'h2);
    chk(msi_addr, 32'h0000_1000);
    chk(msi_data, 32'h0000_00a5);
    wr(pcg_pkg::OFS_IRQ_CTRL, 32'h3);
    wr(pcg_pkg::OFS_CNT + 8'h04, 32'hffff_ffff);
    i_src.send(1'b0, 8'h12);
    settle();
    chk(irq_n, 32'h1);
    chk({31'h0, msi_seen}, 32'h1);
    rd(pcg_pkg::OFS_OVS_SET, 32'h2);
    rd(pcg_pkg::OFS_CNT + 8'h04, 32'h0);
    rd(pcg_pkg::OFS_SHADOW + 8'h04, 32'h0);
    rd(pcg_pkg::OFS_SHADOW, 32'h2);
    i_src.send(1'b0, 8'h55);
    rd(pcg_pkg::OFS_CNT + 8'h04, 32'h1);
    // second overflow while the status bit is still set
    wr(pcg_pkg::OFS_CNT + 8'h04, 32'hffff_ffff);
    i_src.send(1'b0, 8'h12);
    settle();
    chk(irq_n, 32'h2);
    rd(pcg_pkg::OFS_SHADOW, 32'h3);
    // per-counter enable and group enable each mask the interrupt
    for (int i = 0; i < 2; i++) begin
      wr(pcg_pkg::OFS_INTEN, (i == 0) ? 32'h2 : 32'h0);
      wr(pcg_pkg::OFS_IRQ_CTRL, (i == 0) ? 32'h0 : 32'h1);
      wr(pcg_pkg::OFS_CNT + 8'h04, 32'hffff_ffff);
      i_src.send(1'b0, 8'h55);
      settle();
      chk(irq_n, 32'h2);
    end
    rd(pcg_pkg::OFS_OVS_CLR, 32'h2);
    wr(pcg_pkg::OFS_OVS_CLR, 32'h2);
    rd(pcg_pkg::OFS_OVS_SET, 32'h0);
    wr(pcg_pkg::OFS_OVS_SET, 32'h9);
    rd(pcg_pkg::OFS_OVS_CLR, 32'h9);
    wr(pcg_pkg::OFS_OVS_CLR, 32'h1);
    rd(pcg_pkg::OFS_OVS_SET, 32'h8);
    // software and external capture
    wr(pcg_pkg::OFS_CNT, 32'h0000_abcd);
    wr(pcg_pkg::OFS_CAPR, 32'h1);
    rd(pcg_pkg::OFS_SHADOW, 32'h0000_abcd);
    rd(pcg_pkg::OFS_SHADOW + 8'h0c, 32'ha);
    rd(pcg_pkg::OFS_SHADOW, 32'h0000_abcd);
    wr(pcg_pkg::OFS_CNT, 32'h0000_1234);
    i_src.capture();
    rd(pcg_pkg::OFS_SHADOW, 32'h0000_1234);
    // wrap on a tick, then count on in the very next cycle
    wr(pcg_pkg::OFS_OVS_CLR, 32'h8);
    wr(pcg_pkg::OFS_CNT + 8'h0c, 32'hffff_ffff);
    i_src.ticks(3);
    rd(pcg_pkg::OFS_CNT + 8'h0c, 32'h2);
    rd(pcg_pkg::OFS_OVS_SET, 32'h8);
    end_of_test();
  end
endmodule
